// ==== verilog/sfdp_rst_map.svh ====
/*
 * Constants for the flash parameter, reset and status-write block.
 * Assumes inclusion by bare name from both ends; the package does not include it.
 */
`ifndef SFDP_RST_MAP_SVH
`define SFDP_RST_MAP_SVH
`define OP_RESET_ENABLE   8'h66
`define OP_RESET          8'h99
`define OP_WREN_NV        8'h06
`define OP_WREN_VOL       8'h50
`define OP_READ_STATUS    8'h05
`define OP_WRITE_STATUS   8'h01
`define OP_READ_PARAM     8'h5A
`define PARAM_DW16_BASE   8'h68
`define PARAM_DW16_LAST   8'h6B
`define PARAM_B0          8'hE8
`define PARAM_B1          8'h30
`define PARAM_B2          8'hC0
`define PARAM_B3          8'h80
`define STATUS_NV_RESET   8'h00
`define STATUS_BUSY_BIT   0
`define STATUS_WEL_BIT    1
`define ADDR_BYTES        3
`define DUMMY_BYTES       1
`define BYTE_BITS         8
`define FRAME_BITS_PARAM  7'h48
`define FRAME_BITS_STATUS 7'h10
`define FRAME_BITS_OP     7'h08
`define OUT_BITS_PARAM    7'h28
`endif

// ==== verilog/sfdp_rst_pkg.sv ====
/*
 * Types for the two ends: lanes_t shared by both, host_op_t used by the host end only.
 * Assumes sfdp_rst_map.svh on the include path.
 */
package sfdp_rst_pkg;
	typedef enum logic [1:0] {
		LANES_1 = 2'h0,
		LANES_2 = 2'h1,
		LANES_4 = 2'h2
	} lanes_t;
	typedef enum logic [2:0] {
		HOP_NONE   = 3'h0,
		HOP_RESET  = 3'h1,
		HOP_WREN   = 3'h2,
		HOP_WVOL   = 3'h3,
		HOP_WSTAT  = 3'h4,
		HOP_RSTAT  = 3'h5,
		HOP_RPARAM = 3'h6
	} host_op_t;
endpackage : sfdp_rst_pkg

// ==== verilog/spi_link_if.sv ====
/*
 * SPI link between host and flash end: chip select, clock, four data lines.
 * Assumes both ends share one system clock; SCLK is a sampled pin signal.
 */
`timescale 1ns/1ps
`default_nettype none
interface spi_link_if;
	logic       cs_n;
	logic       sclk;
	logic [3:0] host_dq;
	logic [3:0] host_oe;
	logic [3:0] dev_dq;
	logic [3:0] dev_oe;
	modport host (output cs_n, output sclk, output host_dq, output host_oe,
		input dev_dq, input dev_oe);
	modport dev (input cs_n, input sclk, input host_dq, input host_oe,
		output dev_dq, output dev_oe);
endinterface : spi_link_if
`default_nettype wire

// ==== verilog/flash_dev.sv ====
/*
 * Flash end: instruction decode, final parameter doubleword, 66h/99h
 * software reset, 06h/50h status-write selection and busy polling.
 * Assumes SPI mode 0 and host-driven pins, synchronised here by three flops.
 */
// Behaviour
// - parameter bytes 68h-6Bh return E8 30 C0 80
// - no method to enter 4-byte addressing
// - no method to exit 4-byte addressing
// - reset only after 66h then 99h
// - reset accepted on 1, 2, 4 lines
// - host leaves 0-4-4 mode before reset
// - status loads non-volatile copy at power-up
// - 06h sends next status write non-volatile
// - 50h activates overriding volatile status copy
// - reserved bit 7 reads as last written, zero at power-up
// - 05h returns busy bit, one while busy
`timescale 1ns/1ps
`default_nettype none
`include "sfdp_rst_map.svh"
module flash_dev #(
	parameter int BUSY_CYCLES = 16
) (
	// system
	input  wire logic               CLOCK,
	input  wire logic               RESET,
	// link
	spi_link_if.dev                 LINK,
	// mode and status view
	input  wire sfdp_rst_pkg::lanes_t LANES,
	output logic                    SOFT_RESET,
	output logic [7:0]              STATUS,
	output logic                    VOL_ACTIVE
);
	import sfdp_rst_pkg::*;

	typedef enum logic [3:0] {
		S_OP   = 4'b0001,
		S_ADDR = 4'b0010,
		S_DATA = 4'b0100,
		S_IGN  = 4'b1000
	} dstate_t;

	logic [2:0] cs_sync_q, clk_sync_q;
	logic [3:0] dq_sync1_q, dq_sync2_q, dq_sync3_q, dq_q;
	logic       cs_n_q, sclk_q;
	// a data line counts only once the last two stages agree
	wire [3:0]  dq_d = ((dq_sync2_q ~^ dq_sync3_q) & dq_sync3_q) |
		((dq_sync2_q ^ dq_sync3_q) & dq_q);
	always_ff @(posedge CLOCK) begin
		cs_sync_q  <= {cs_sync_q[1:0], LINK.cs_n};
		clk_sync_q <= {clk_sync_q[1:0], LINK.sclk};
		dq_sync1_q <= LINK.host_dq;
		dq_sync2_q <= dq_sync1_q;
		dq_sync3_q <= dq_sync2_q;
		if (RESET) begin
			cs_n_q <= 1'b1;
			sclk_q <= 1'b0;
			dq_q   <= 4'h0;
		end else begin
			dq_q   <= dq_d;
			if (cs_sync_q[2] == cs_sync_q[1])
				cs_n_q <= cs_sync_q[2];
			if (clk_sync_q[2] == clk_sync_q[1])
				sclk_q <= clk_sync_q[2];
		end
	end

	logic cs_n_d1_q, sclk_d1_q;
	always_ff @(posedge CLOCK) begin
		cs_n_d1_q <= RESET ? 1'b1 : cs_n_q;
		sclk_d1_q <= RESET ? 1'b0 : sclk_q;
	end
	wire rise       = sclk_q & ~sclk_d1_q & ~cs_n_q;
	wire fall       = ~sclk_q & sclk_d1_q & ~cs_n_q;
	wire frame_end  = cs_n_q & ~cs_n_d1_q;
	wire frame_open = ~cs_n_q & cs_n_d1_q;

	// shift width per edge follows the current operating mode
	wire [3:0] step = (LANES == LANES_4) ? 4'h4 : (LANES == LANES_2) ? 4'h2 : 4'h1;
	wire [7:0] sh_in = (LANES == LANES_4) ? {4'h0, dq_q} :
		(LANES == LANES_2) ? {6'h00, dq_q[1:0]} : {7'h00, dq_q[0]};

	dstate_t    st_q;
	logic [7:0] sr_q, op_q, tx_q;
	logic [3:0] bits_q;
	logic [1:0] abytes_q;
	logic [7:0] addr_q;
	logic       rst_armed_q, pend_enable_q;
	logic       wen_nv_q, wen_vol_q;
	logic [7:0] nv_status_q, vol_status_q;
	logic [15:0] busy_cnt_q;

	wire [3:0] bits_n   = bits_q + step;
	wire       byte_done = rise & (bits_n >= 4'(`BYTE_BITS));
	wire [7:0] shifted  = (LANES == LANES_4) ? {sr_q[3:0], 4'h0} :
		(LANES == LANES_2) ? {sr_q[5:0], 2'h0} : {sr_q[6:0], 1'b0};
	wire [7:0] rx_byte  = shifted | sh_in;
	wire       busy     = |busy_cnt_q;

	// final doubleword: enter/exit 4-byte fields say not supported
	wire [7:0] param_byte = (addr_q == `PARAM_DW16_BASE)      ? `PARAM_B0 :
		(addr_q == `PARAM_DW16_BASE + 8'h01) ? `PARAM_B1 :
		(addr_q == `PARAM_DW16_BASE + 8'h02) ? `PARAM_B2 :
		(addr_q == `PARAM_DW16_LAST)         ? `PARAM_B3 : 8'hFF;
	wire [7:0] cur_status = VOL_ACTIVE ? vol_status_q : nv_status_q;
	wire [7:0] live_status = {cur_status[7:2], wen_nv_q | wen_vol_q, busy};
	wire [7:0] data_byte = (op_q == `OP_READ_STATUS) ? live_status : param_byte;

	wire is_op   = (st_q == S_OP) & byte_done;
	wire do_rst  = is_op & (rx_byte == `OP_RESET) & rst_armed_q;
	wire wr_stat = (st_q == S_DATA) & byte_done & (op_q == `OP_WRITE_STATUS);

	always_ff @(posedge CLOCK) begin
		if (RESET || frame_open || do_rst) begin
			st_q     <= S_OP;
			bits_q   <= 4'h0;
			sr_q     <= 8'h00;
			abytes_q <= 2'h0;
		end else if (byte_done) begin
			bits_q <= 4'h0;
			sr_q   <= 8'h00;
			unique case (st_q)
				S_OP: begin
					op_q <= rx_byte;
					st_q <= (rx_byte == `OP_READ_PARAM) ? S_ADDR :
						(rx_byte == `OP_READ_STATUS || rx_byte == `OP_WRITE_STATUS)
						? S_DATA : S_IGN;
				end
				S_ADDR: begin
					abytes_q <= abytes_q + 2'h1;
					// dummy byte must not overwrite the address
					if (abytes_q == 2'(`ADDR_BYTES)) st_q <= S_DATA;
					else addr_q <= rx_byte;
				end
				S_DATA: addr_q <= addr_q + 8'h01;
				S_IGN: ;
			endcase
		end else if (rise) begin
			bits_q <= bits_n;
			sr_q   <= rx_byte;
		end
	end

	// only whole frames count; enable survives exactly one following frame
	always_ff @(posedge CLOCK) begin
		if (RESET || do_rst) begin
			rst_armed_q   <= 1'b0;
			pend_enable_q <= 1'b0;
		end else if (is_op) begin
			pend_enable_q <= (rx_byte == `OP_RESET_ENABLE);
			rst_armed_q   <= 1'b0;
		end else if (frame_end) begin
			rst_armed_q   <= pend_enable_q;
			pend_enable_q <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			nv_status_q  <= `STATUS_NV_RESET;
			vol_status_q <= `STATUS_NV_RESET;
			VOL_ACTIVE   <= 1'b0;
			wen_nv_q     <= 1'b0;
			wen_vol_q    <= 1'b0;
			busy_cnt_q   <= 16'h0000;
		end else if (do_rst) begin
			vol_status_q <= nv_status_q;
			VOL_ACTIVE   <= 1'b0;
			wen_nv_q     <= 1'b0;
			wen_vol_q    <= 1'b0;
			busy_cnt_q   <= 16'h0000;
		end else begin
			if (busy) busy_cnt_q <= busy_cnt_q - 16'h0001;
			if (is_op && rx_byte == `OP_WREN_NV) begin
				wen_nv_q  <= 1'b1;
				wen_vol_q <= 1'b0;
			end
			if (is_op && rx_byte == `OP_WREN_VOL) begin
				wen_vol_q  <= 1'b1;
				wen_nv_q   <= 1'b0;
				VOL_ACTIVE <= 1'b1;
			end
			if (wr_stat && wen_nv_q && !busy) begin
				nv_status_q  <= {rx_byte[7:2], 2'b00};
				vol_status_q <= {rx_byte[7:2], 2'b00};
				VOL_ACTIVE   <= 1'b0;
				busy_cnt_q   <= 16'(BUSY_CYCLES);
				wen_nv_q     <= 1'b0;
			end else if (wr_stat && wen_vol_q) begin
				vol_status_q <= {rx_byte[7:2], 2'b00};
				wen_vol_q    <= 1'b0;
			end
		end
	end

	// output shifts on falling edge so host samples it on the next rise
	wire       tx_idle  = RESET | cs_n_q | (st_q != S_DATA) | (op_q == `OP_WRITE_STATUS);
	wire [7:0] tx_shift = (LANES == LANES_4) ? {tx_q[3:0], 4'h0} :
		(LANES == LANES_2) ? {tx_q[5:0], 2'h0} : {tx_q[6:0], 1'b0};
	wire [7:0] tx_d     = tx_idle ? 8'h00 : (fall && bits_q == 4'h0) ? data_byte :
		fall ? tx_shift : tx_q;
	wire [3:0] dev_dq_d = (LANES == LANES_4) ? tx_d[7:4] :
		(LANES == LANES_2) ? {2'b00, tx_d[7:6]} : {2'b00, tx_d[7], 1'b0};
	always_ff @(posedge CLOCK) begin
		tx_q        <= tx_d;
		// pin straight from a flop, so it never glitches
		LINK.dev_dq <= dev_dq_d;
		if (tx_idle) begin
			LINK.dev_oe <= 4'h0;
		end else if (fall && bits_q == 4'h0) begin
			LINK.dev_oe <= (LANES == LANES_4) ? 4'hF : (LANES == LANES_2) ? 4'h3 : 4'h2;
		end
	end

	always_ff @(posedge CLOCK) begin
		SOFT_RESET <= RESET ? 1'b0 : do_rst;
		STATUS     <= RESET ? 8'h00 : live_status;
	end
endmodule : flash_dev
`default_nettype wire

// ==== verilog/flash_host.sv ====
/*
 * Host end: issues one framed instruction per request, two (66h then 99h) for reset, and returns read data.
 * Assumes the flash end samples pins through synchronisers; SCLK is slow.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sfdp_rst_map.svh"
module flash_host #(
	parameter int HALF_CYCLES = 8
) (
	// system
	input  wire logic                  CLOCK,
	input  wire logic                  RESET,
	// request
	input  wire logic                  REQ,
	input  wire sfdp_rst_pkg::host_op_t OP,
	input  wire logic [7:0]            WDATA,
	input  wire sfdp_rst_pkg::lanes_t  LANES,
	output logic                       BUSY,
	output logic                       DONE,
	output logic [31:0]                RDATA,
	// link
	spi_link_if.host                   LINK
);
	import sfdp_rst_pkg::*;

	typedef enum logic [3:0] {
		H_IDLE  = 4'b0001,
		H_SHIFT = 4'b0010,
		H_GAP   = 4'b0100,
		H_DONE  = 4'b1000
	} hstate_t;

	hstate_t     st_q;
	logic [7:0]  cnt_q;
	logic [63:0] tx_q;
	logic [6:0]  nbits_q, txbits_q;
	logic [6:0]  done_q;
	logic [31:0] rx_q;
	logic        second_q;
	host_op_t    op_q;

	wire [6:0] step = (LANES == LANES_4) ? 7'h4 : (LANES == LANES_2) ? 7'h2 : 7'h1;
	// reset goes out as two frames: enable, then reset
	// host never enters 0-4-4 mode, so nothing to leave first
	wire [7:0] opcode = (op_q == HOP_RESET) ? (second_q ? `OP_RESET : `OP_RESET_ENABLE) :
		(op_q == HOP_WREN) ? `OP_WREN_NV :
		(op_q == HOP_WVOL) ? `OP_WREN_VOL :
		(op_q == HOP_WSTAT) ? `OP_WRITE_STATUS :
		(op_q == HOP_RSTAT) ? `OP_READ_STATUS : `OP_READ_PARAM;
	wire [6:0] frame_bits = (op_q == HOP_RPARAM) ? `FRAME_BITS_PARAM :
		(op_q == HOP_WSTAT || op_q == HOP_RSTAT) ? `FRAME_BITS_STATUS : `FRAME_BITS_OP;
	wire [6:0] out_bits = (op_q == HOP_RPARAM) ? `OUT_BITS_PARAM :
		(op_q == HOP_WSTAT) ? `FRAME_BITS_STATUS : `FRAME_BITS_OP;
	wire [63:0] frame = {opcode, (op_q == HOP_RPARAM) ? {16'h0000, `PARAM_DW16_BASE}
		: {WDATA, 16'h0000}, 32'h0000_0000};
	wire half = (cnt_q == 8'(HALF_CYCLES - 1));
	wire [3:0] rx_lanes = (LANES == LANES_4) ? LINK.dev_dq :
		(LANES == LANES_2) ? {2'b00, LINK.dev_dq[1:0]} : {3'b000, LINK.dev_dq[1]};

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			st_q <= H_IDLE;
			LINK.cs_n <= 1'b1;
			LINK.sclk <= 1'b0;
			LINK.host_oe <= 4'h0;
			LINK.host_dq <= 4'h0;
			cnt_q <= 8'h00;
			BUSY <= 1'b0;
			DONE <= 1'b0;
			RDATA <= 32'h0;
			second_q <= 1'b0;
			op_q <= HOP_NONE;
			nbits_q <= 7'h00;
			txbits_q <= 7'h00;
			tx_q <= 64'h0;
			rx_q <= 32'h0;
			done_q <= 7'h00;
		end else begin
			DONE <= 1'b0;
			unique case (st_q)
				H_IDLE: if (REQ && OP != HOP_NONE) begin
					op_q <= OP;
					second_q <= 1'b0;
					BUSY <= 1'b1;
					cnt_q <= 8'h00;
					st_q <= H_GAP;
				end
				H_GAP: begin
					cnt_q <= cnt_q + 8'h01;
					if (half) begin
						cnt_q <= 8'h00;
						LINK.cs_n <= 1'b0;
						tx_q <= frame;
						nbits_q <= frame_bits;
						txbits_q <= out_bits;
						done_q <= 7'h00;
						rx_q <= 32'h0;
						LINK.host_oe <= (LANES == LANES_4) ? 4'hF :
							(LANES == LANES_2) ? 4'h3 : 4'h1;
						LINK.host_dq <= (LANES == LANES_4) ? frame[63:60] :
							(LANES == LANES_2) ? {2'b00, frame[63:62]} : {3'b000, frame[63]};
						st_q <= H_SHIFT;
					end
				end
				H_SHIFT: begin
					cnt_q <= cnt_q + 8'h01;
					if (half) begin
						cnt_q <= 8'h00;
						LINK.sclk <= ~LINK.sclk;
						if (!LINK.sclk) begin
							done_q <= done_q + step;
							if (done_q >= txbits_q) rx_q <= (rx_q << step) | {28'h0, rx_lanes};
						end else if (done_q >= nbits_q) begin
							LINK.sclk <= 1'b0;
							LINK.cs_n <= 1'b1;
							LINK.host_oe <= 4'h0;
							st_q <= (op_q == HOP_RESET && !second_q) ? H_GAP : H_DONE;
							second_q <= 1'b1;
						end else begin
							tx_q <= tx_q << step;
							LINK.host_oe <= (done_q >= txbits_q) ? 4'h0 : LINK.host_oe;
							LINK.host_dq <= (LANES == LANES_4) ? tx_q[59:56] :
								(LANES == LANES_2) ? {2'b00, tx_q[61:60]} : {3'b000, tx_q[62]};
						end
					end
				end
				H_DONE: begin
					// parameter bytes arrive lowest first; keep first-received in low lane
					RDATA <= (op_q == HOP_RPARAM) ?
						{rx_q[7:0], rx_q[15:8], rx_q[23:16], rx_q[31:24]} : {24'h0, rx_q[7:0]};
					DONE <= 1'b1;
					BUSY <= 1'b0;
					st_q <= H_IDLE;
				end
			endcase
		end
	end
endmodule : flash_host
`default_nettype wire

// ==== tb/sfdp_rst_assertions.sv ====
/*
 * Link checker for the host and flash ends: framing, clock phase, line ownership.
 * Assumes it is instantiated beside the link, one clock, reset synchronous active high.
 */
`timescale 1ns/1ps
`default_nettype none
module sfdp_rst_assertions (
	// system
	input wire logic       CLOCK,
	input wire logic       RESET,
	// link
	input wire logic       cs_n,
	input wire logic       sclk,
	input wire logic [3:0] host_dq,
	input wire logic [3:0] host_oe,
	input wire logic [3:0] dev_dq,
	input wire logic [3:0] dev_oe
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RESET);
	idle_after_reset_a: assert property ($fell(RESET) |-> cs_n && host_oe == 4'h0 && dev_oe == 4'h0)
		else $error("link not idle after reset");
	dev_quiet_idle_a: assert property (cs_n [*8] |-> dev_oe == 4'h0)
		else $error("flash end drives outside a frame");
	no_contention_a: assert property ((host_oe & dev_oe) == 4'h0)
		else $error("both ends drive one line");
	clk_idle_a: assert property (cs_n |-> !sclk)
		else $error("serial clock high outside a frame");
	clk_high_time_a: assert property ($rose(sclk) |-> sclk [*7] ##[1:2] !sclk)
		else $error("serial clock high phase wrong");
	host_setup_a: assert property ($changed(host_dq) && host_oe != 4'h0 |-> !sclk)
		else $error("host data moved while clock high");
	dev_launch_a: assert property ($changed(dev_dq) && dev_oe != 4'h0 |-> !sclk)
		else $error("flash data moved while clock high");
	dev_oe_edge_a: assert property ($changed(dev_oe) |-> !sclk)
		else $error("flash enable moved while clock high");
	cover property ($fell(cs_n));
	cover property (dev_oe == 4'h2);
	cover property (dev_oe == 4'h3);
	cover property (dev_oe == 4'hF);
endmodule : sfdp_rst_assertions
`default_nettype wire

// ==== tb/sfdp_reset_status_write_control_test.sv ====
/*
 * Testbench: host end against flash end, plus a bit-banged link to a second flash end.
 * Assumes the design package and map header are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module sfdp_reset_status_write_control_test;
	import sfdp_rst_pkg::*;
	logic        clock = 0, reset = 1, req = 0, busy, done, soft1, soft2, vol;
	host_op_t    op_s = HOP_NONE;
	lanes_t      lanes = LANES_1;
	logic [7:0]  wdata = 8'h00, status;
	logic [31:0] rdata;
	int          err_total = 0, compares = 0, srst1 = 0, srst2 = 0, b;
	spi_link_if u_spi_link_if ();
	spi_link_if u_link2 ();
	// long busy so the first poll after a write still sees it
	flash_dev #(.BUSY_CYCLES(2000)) u_flash_dev (.CLOCK(clock), .RESET(reset),
		.LINK(u_spi_link_if), .LANES(lanes), .SOFT_RESET(soft1), .STATUS(status),
		.VOL_ACTIVE(vol));
	flash_host u_flash_host (.CLOCK(clock), .RESET(reset), .REQ(req), .OP(op_s),
		.WDATA(wdata), .LANES(lanes), .BUSY(busy), .DONE(done), .RDATA(rdata),
		.LINK(u_spi_link_if));
	flash_dev u_flash_dev2 (.CLOCK(clock), .RESET(reset), .LINK(u_link2), .LANES(LANES_1),
		.SOFT_RESET(soft2), .STATUS(), .VOL_ACTIVE());
	sfdp_rst_assertions u_sfdp_rst_assertions (.CLOCK(clock), .RESET(reset),
		.cs_n(u_spi_link_if.cs_n), .sclk(u_spi_link_if.sclk),
		.host_dq(u_spi_link_if.host_dq), .host_oe(u_spi_link_if.host_oe),
		.dev_dq(u_spi_link_if.dev_dq), .dev_oe(u_spi_link_if.dev_oe));
	always #25 clock = ~clock;
	always @(posedge clock) begin
		if (soft1 === 1'b1) srst1++;
		if (soft2 === 1'b1) srst2++;
	end
	task check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task end_sim();
		$display("comparisons %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : end_sim
	task run(input host_op_t o, input logic [7:0] w, input lanes_t l);
		int n;
		n = 0;
		@(posedge clock);
		req <= 1'b1; op_s <= o; wdata <= w; lanes <= l;
		@(posedge clock);
		req <= 1'b0;
		do begin
			@(posedge clock);
			#1;
			n++;
			if (n == 1) check(busy, 1'b1);
		end while (done !== 1'b1 && n < 20000);
		if (n >= 20000) check(0, 1);
		check(busy, 1'b0);
	endtask : run
	// the far-end pins go to an inverted value once released
	task frame2(input logic [7:0] v);
		@(posedge clock);
		u_link2.cs_n <= 1'b0; u_link2.host_oe <= 4'h1;
		for (int i = 7; i >= 0; i--) begin
			repeat (8) @(posedge clock);
			u_link2.host_dq <= {3'h0, v[i]};
			repeat (8) @(posedge clock);
			u_link2.sclk <= 1'b1;
			repeat (8) @(posedge clock);
			u_link2.sclk <= 1'b0;
		end
		repeat (8) @(posedge clock);
		u_link2.cs_n <= 1'b1; u_link2.host_oe <= 4'h0; u_link2.host_dq <= ~u_link2.host_dq;
		repeat (16) @(posedge clock);
	endtask : frame2
	initial begin
		#2_000_000;
		err_total++;
		end_sim();
	end
	initial begin
		u_link2.cs_n = 1'b1; u_link2.sclk = 1'b0; u_link2.host_dq = 4'h0; u_link2.host_oe = 4'h0;
		repeat (8) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock) #1;
		check(status, 8'h00);
		check(vol, 0);
		for (int l = 0; l < 3; l++) begin
			run(HOP_RPARAM, 8'h00, lanes_t'(l));
			check(rdata, 32'h80C030E8);
			check(rdata[31:24], 8'h80);
			check(rdata[23:14], 10'h300);
			check(rdata[7], 1);
		end
		$display("parameter doubleword test done");
		run(HOP_WREN, 8'h00, LANES_1);
		run(HOP_WSTAT, 8'hFC, LANES_1);
		run(HOP_RSTAT, 8'h00, LANES_1);
		check(rdata[0], 1);
		for (int n = 0; n < 20 && rdata[0] !== 1'b0; n++) run(HOP_RSTAT, 8'h00, LANES_1);
		check(rdata[7:0], 8'hFC);
		check(vol, 0);
		$display("non-volatile write test done");
		for (int l = 0; l < 3; l++) begin
			run(HOP_WVOL, 8'h00, lanes_t'(l));
			run(HOP_WSTAT, 8'h30, lanes_t'(l));
			check(vol, 1);
			check(status, 8'h30);
			b = srst1;
			run(HOP_RESET, 8'h00, lanes_t'(l));
			repeat (4) @(posedge clock);
			check(srst1 - b, 1);
			check(vol, 0);
			check(status, 8'hFC);
		end
		$display("volatile and reset test done");
		b = srst2;
		frame2(8'h66);
		frame2(8'h05);
		frame2(8'h99);
		check(srst2 - b, 0);
		frame2(8'h66);
		frame2(8'h99);
		check(srst2 - b, 1);
		$display("reset pairing test done");
		end_sim();
	end
endmodule : sfdp_reset_status_write_control_test
`default_nettype wire
